/* File: clock_dist_pkg.sv */
// constants and types for the clock distribution configuration registers
// Contract
// [RQ1] The host writes bits 7:4 of the port configuration register as a mirror of bits 3:0.
// [RQ2] Only 16-bit instructions are used, and the instruction-length bit resets to 1.
// [RQ3] Soft reset bit 2 holds all other registers at their defaults until the host writes it back to 0.
// [RQ4] The update-all-registers bit at 0x232 clears itself after a write of 1.
// [RQ5] Bit 1 of the port configuration register selects MSB-first or LSB-first serial words.
// [RQ6] MSB-first mode decrements the address per byte, and LSB-first mode increments it.
// [RQ7] Serial-output-active 0 returns reads on the data pin with the output pin released; 1 returns reads on the output pin.
// [RQ8] Readback-select chooses buffer registers (0) or active registers (1) for reads.
// [RQ9] An update copies every buffered register into the active registers in one step.
package clock_dist_pkg;

  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_READBACK = 13'h0004;
  localparam logic [12:0] ADDR_DIV1_AUX = 13'h0195;
  localparam logic [12:0] ADDR_DIV2_CYCLES = 13'h0196;
  localparam logic [12:0] ADDR_DIV2_PHASE = 13'h0197;
  localparam logic [12:0] ADDR_DIV2_AUX = 13'h0198;
  localparam logic [12:0] ADDR_VCO_DIV = 13'h01e0;
  localparam logic [12:0] ADDR_CLK_IN = 13'h01e1;
  localparam logic [12:0] ADDR_PDN_ALIGN = 13'h0230;
  localparam logic [12:0] ADDR_SYS_RSVD = 13'h0231;
  localparam logic [12:0] ADDR_UPDATE = 13'h0232;

  // port config reset: long instruction bit 3 and its mirror bit 4
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_DEFAULT = 8'h00;
  localparam logic [7:0] RST_VCO_DIV = 8'h02;

  localparam int CFG_OUT_ACTIVE_BIT = 0;
  localparam int CFG_LSB_FIRST_BIT = 1;
  localparam int CFG_SOFT_RESET_BIT = 2;
  localparam int CFG_LONG_INSTR_BIT = 3;
  localparam int READBACK_ACTIVE_BIT = 0;
  localparam int UPDATE_BIT = 0;

  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  localparam int NUM_BUF = 7;
  localparam logic [2:0] BUF_NONE = 3'h7;
  localparam logic [2:0] BUF_VCO_IDX = 3'h4;

  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdio;
  } serial_pins_t;

  typedef struct packed {
    logic [7:0] div1_aux;
    logic [7:0] div2_cycles;
    logic [7:0] div2_phase;
    logic [7:0] div2_aux;
    logic [7:0] vco_divide;
    logic [7:0] clk_in_sel;
    logic [7:0] pdn_align;
  } active_regs_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } port_state_t;

endpackage

/* File: clock_dist_config_regs.sv */
// serial control port and buffered configuration register bank
`timescale 1ns/1ps
module clock_dist_config_regs (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire clock_dist_pkg::serial_pins_t i_pins,
  output logic o_sdio,
  output logic o_sdio_oe_n,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_soft_reset,
  output clock_dist_pkg::active_regs_t o_active
);
  import clock_dist_pkg::*;

  function automatic logic [2:0] buf_index(input logic [12:0] a);
    case (a)
      ADDR_DIV1_AUX: buf_index = 3'h0;
      ADDR_DIV2_CYCLES: buf_index = 3'h1;
      ADDR_DIV2_PHASE: buf_index = 3'h2;
      ADDR_DIV2_AUX: buf_index = 3'h3;
      ADDR_VCO_DIV: buf_index = 3'h4;
      ADDR_CLK_IN: buf_index = 3'h5;
      ADDR_PDN_ALIGN: buf_index = 3'h6;
      default: buf_index = BUF_NONE;
    endcase
  endfunction

  function automatic logic [7:0] buf_default(input int idx);
    buf_default = (idx == int'(BUF_VCO_IDX)) ? RST_VCO_DIV : RST_DEFAULT;
  endfunction

  // pin synchronisers; first stage feeds only the second
  serial_pins_t sync1_ff, sync2_ff;
  logic sclk_d_ff;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_ff <= '{csb_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      sync2_ff <= '{csb_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      sclk_d_ff <= 1'b0;
    end else begin
      sync1_ff <= i_pins;
      sync2_ff <= sync1_ff;
      sclk_d_ff <= sync2_ff.sclk;
    end
  end

  logic sclk_rise, sclk_fall, sel_active, bit_in;
  assign sclk_rise = sync2_ff.sclk & ~sclk_d_ff;
  assign sclk_fall = ~sync2_ff.sclk & sclk_d_ff;
  assign sel_active = ~sync2_ff.csb_n;
  assign bit_in = sync2_ff.sdio;

  // register state
  logic [7:0] port_cfg_ff, nxt_port_cfg;
  logic readback_sel_ff, nxt_readback_sel;
  logic update_ff, nxt_update;
  logic [7:0] buf_ff [NUM_BUF];
  logic [7:0] nxt_buf [NUM_BUF];
  logic [7:0] act_ff [NUM_BUF];
  logic [7:0] nxt_act [NUM_BUF];

  logic lsb_first, out_pin_sel, soft_reset;
  assign lsb_first = port_cfg_ff[CFG_LSB_FIRST_BIT];
  assign out_pin_sel = port_cfg_ff[CFG_OUT_ACTIVE_BIT];
  assign soft_reset = port_cfg_ff[CFG_SOFT_RESET_BIT];

  // serial port state
  port_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [15:0] shift_ff, nxt_shift;
  logic [12:0] addr_ff, nxt_addr;
  logic read_ff, nxt_read;
  logic stream_ff, nxt_stream;
  logic [1:0] left_ff, nxt_left;
  logic [7:0] tx_ff, nxt_tx;
  logic sdio_ff, nxt_sdio, sdio_oe_n_ff, nxt_sdio_oe_n;
  logic sdo_ff, nxt_sdo, sdo_oe_n_ff, nxt_sdo_oe_n;

  logic wr_en;
  logic [12:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_byte;
  logic [15:0] instr_word;
  logic [7:0] data_byte;
  logic [2:0] rd_idx;

  always_comb begin
    rd_idx = buf_index(rd_addr);
    if (rd_idx != BUF_NONE) begin
      rd_byte = readback_sel_ff ? act_ff[rd_idx] : buf_ff[rd_idx]; // RQ8
    end else begin
      unique case (rd_addr)
        ADDR_PORT_CFG: rd_byte = port_cfg_ff;
        ADDR_READBACK: rd_byte = {7'h00, readback_sel_ff};
        ADDR_UPDATE: rd_byte = {7'h00, update_ff};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_read = read_ff;
    nxt_stream = stream_ff;
    nxt_left = left_ff;
    nxt_tx = tx_ff;
    nxt_sdio = sdio_ff;
    nxt_sdio_oe_n = sdio_oe_n_ff;
    nxt_sdo = sdo_ff;
    nxt_sdo_oe_n = sdo_oe_n_ff;
    wr_en = 1'b0;
    wr_addr = addr_ff;
    wr_data = 8'h00;
    rd_addr = addr_ff;
    // word order follows the live bit-order setting
    instr_word = lsb_first ? {bit_in, shift_ff[15:1]}
                           : {shift_ff[14:0], bit_in}; // RQ5
    data_byte = lsb_first ? {bit_in, shift_ff[7:1]}
                          : {shift_ff[6:0], bit_in}; // RQ5
    if (!sel_active) begin
      nxt_state = ST_IDLE;
      nxt_cnt = 4'h0;
      nxt_sdio_oe_n = 1'b1;
      nxt_sdo_oe_n = 1'b1;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_INSTR;
          nxt_cnt = 4'h0;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            nxt_shift = instr_word;
            nxt_cnt = cnt_ff + 4'h1;
            // always a 16-bit instruction, the short form is not decoded
            if (cnt_ff == INSTR_LAST_BIT) begin // RQ2
              nxt_state = ST_DATA;
              nxt_cnt = 4'h0;
              nxt_read = instr_word[INSTR_RW_BIT];
              nxt_left = instr_word[INSTR_LEN_HI:INSTR_LEN_LO];
              nxt_stream = nxt_left == LEN_STREAM;
              nxt_addr = instr_word[12:0];
              rd_addr = instr_word[12:0];
              nxt_tx = rd_byte;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            nxt_shift = {shift_ff[15:8], data_byte};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == BYTE_LAST_BIT) begin
              nxt_cnt = 4'h0;
              wr_en = ~read_ff;
              wr_data = data_byte;
              nxt_addr = lsb_first ? addr_ff + 13'h0001
                                   : addr_ff - 13'h0001; // RQ6
              rd_addr = nxt_addr;
              nxt_tx = rd_byte;
              if (!stream_ff && left_ff == 2'h0) begin
                nxt_state = ST_DONE;
              end else if (!stream_ff) begin
                nxt_left = left_ff - 2'h1;
              end
            end
          end else if (sclk_fall && read_ff) begin
            nxt_tx = lsb_first ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
            if (out_pin_sel) begin // RQ7
              nxt_sdo = lsb_first ? tx_ff[0] : tx_ff[7];
              nxt_sdo_oe_n = 1'b0;
            end else begin
              nxt_sdio = lsb_first ? tx_ff[0] : tx_ff[7];
              nxt_sdio_oe_n = 1'b0;
            end
          end
        end
        ST_DONE: begin
          if (sclk_fall) begin
            nxt_sdio_oe_n = 1'b1;
            nxt_sdo_oe_n = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 16'h0000;
      addr_ff <= 13'h0000;
      read_ff <= 1'b0;
      stream_ff <= 1'b0;
      left_ff <= 2'h0;
      tx_ff <= 8'h00;
      sdio_ff <= 1'b0;
      sdio_oe_n_ff <= 1'b1;
      sdo_ff <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      read_ff <= nxt_read;
      stream_ff <= nxt_stream;
      left_ff <= nxt_left;
      tx_ff <= nxt_tx;
      sdio_ff <= nxt_sdio;
      sdio_oe_n_ff <= nxt_sdio_oe_n;
      sdo_ff <= nxt_sdo;
      sdo_oe_n_ff <= nxt_sdo_oe_n;
    end
  end

  logic [2:0] wr_idx;

  always_comb begin
    nxt_port_cfg = port_cfg_ff;
    nxt_readback_sel = readback_sel_ff;
    nxt_update = 1'b0; // RQ4
    nxt_buf = buf_ff;
    nxt_act = act_ff;
    wr_idx = buf_index(wr_addr);
    // transfer uses the pre-write buffer, so a same-cycle write waits
    if (update_ff) begin
      nxt_act = buf_ff; // RQ9
    end
    if (wr_en) begin
      if (wr_idx != BUF_NONE) begin
        nxt_buf[wr_idx] = wr_data;
      end else if (wr_addr == ADDR_PORT_CFG) begin
        nxt_port_cfg = wr_data; // RQ1
      end else if (wr_addr == ADDR_READBACK) begin
        nxt_readback_sel = wr_data[READBACK_ACTIVE_BIT];
      end else if (wr_addr == ADDR_UPDATE) begin
        nxt_update = wr_data[UPDATE_BIT];
      end
    end
    // soft reset spares its own register so the host can release it
    if (soft_reset) begin // RQ3
      nxt_readback_sel = 1'b0;
      nxt_update = 1'b0;
      for (int i = 0; i < NUM_BUF; i++) begin
        nxt_buf[i] = buf_default(i);
        nxt_act[i] = buf_default(i);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_cfg_ff <= RST_PORT_CFG; // RQ2
      readback_sel_ff <= 1'b0;
      update_ff <= 1'b0;
      for (int i = 0; i < NUM_BUF; i++) begin
        buf_ff[i] <= buf_default(i);
        act_ff[i] <= buf_default(i);
      end
    end else begin
      port_cfg_ff <= nxt_port_cfg;
      readback_sel_ff <= nxt_readback_sel;
      update_ff <= nxt_update;
      buf_ff <= nxt_buf;
      act_ff <= nxt_act;
    end
  end

  assign o_sdio = sdio_ff;
  assign o_sdio_oe_n = sdio_oe_n_ff;
  assign o_sdo = sdo_ff;
  assign o_sdo_oe_n = sdo_oe_n_ff;
  assign o_soft_reset = port_cfg_ff[CFG_SOFT_RESET_BIT];
  assign o_active = {act_ff[0], act_ff[1], act_ff[2], act_ff[3],
                     act_ff[4], act_ff[5], act_ff[6]};

  instr_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ2
    state_ff == ST_INSTR && sel_active && sclk_rise && cnt_ff == 4'hf
    |=> state_ff == ST_DATA && cnt_ff == 4'h0)
    else $error("instruction did not end after 16 bits");
  soft_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ3
    soft_reset |=> o_active.vco_divide == RST_VCO_DIV && !readback_sel_ff)
    else $error("soft reset did not restore defaults");
  reset_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ3
    soft_reset && !wr_en |=> soft_reset)
    else $error("soft reset bit cleared itself");
  update_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ4
    update_ff |=> !update_ff)
    else $error("update bit did not clear itself");
  bit_order_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ5
    wr_en |-> (lsb_first ? wr_data[7] : wr_data[0]) == bit_in)
    else $error("last data bit landed in wrong position");
  addr_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ6
    wr_en && sel_active ##1 state_ff == ST_DATA
    |-> addr_ff == ($past(lsb_first) ? $past(addr_ff) + 13'h0001
                                     : $past(addr_ff) - 13'h0001))
    else $error("address stepped the wrong way");
  out_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ7
    !o_sdo_oe_n || !o_sdio_oe_n |-> $past(out_pin_sel) == !o_sdo_oe_n)
    else $error("read data on the wrong pin");
  readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ8
    readback_sel_ff && rd_addr == ADDR_VCO_DIV |-> rd_byte == o_active.vco_divide)
    else $error("readback ignored active bank");
  update_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ9
    update_ff && !soft_reset |=> o_active.div2_cycles == $past(buf_ff[1])
      && o_active.pdn_align == $past(buf_ff[6]))
    else $error("update did not copy buffer to active");

endmodule // clock_dist_config_regs

/* File: serial_host_model.sv */
// host controller model driving the serial control port
`timescale 1ns/1ps
module serial_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sdio,
  input wire logic i_sdio_oe_n,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n,
  output clock_dist_pkg::serial_pins_t o_pins
);
  import clock_dist_pkg::*;
  logic host_d = 1'b0;
  logic csb_n = 1'b1;
  logic sclk = 1'b0;
  logic [1:0] last_oe = 2'b11;
  // data pin resolves to the device only while it enables its driver
  assign o_pins = {csb_n, sclk, i_sdio_oe_n ? host_d : i_sdio};

  function automatic logic [7:0] cfg_byte(input logic [3:0] lo);
    return {lo[0], lo[1], lo[2], lo[3], lo};
  endfunction

  // 5 clk low then 5 clk high keeps sclk well under 25 MHz
  task automatic slot(input logic d, input logic drv, output logic q);
    if (drv) host_d = d;
    repeat (5) @(posedge i_clk_sys);
    q = i_sdo_oe_n ? o_pins.sdio : i_sdo;
    last_oe = {i_sdio_oe_n, i_sdo_oe_n};
    #1 sclk = 1'b1;
    repeat (5) @(posedge i_clk_sys);
    #1 sclk = 1'b0;
  endtask

  // first byte of a frame sits in the top byte of the n-byte word
  task automatic xfer(input logic lsb, input logic rd, input logic [12:0] a,
                      input int n, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic [1:0] oe);
    logic [15:0] ins;
    logic q;
    int k;
    ins = {rd, 2'(n - 1), a};
    rdat = '0;
    @(posedge i_clk_sys);
    #1 csb_n = 1'b0;
    for (int i = 0; i < 16; i++)
      slot(ins[lsb ? i : 15 - i], 1'b1, q);
    // released line must not keep looking like the last bit
    if (rd) host_d = ~host_d;
    for (int b = 0; b < n; b++)
      for (int i = 0; i < 8; i++) begin
        k = 8 * (n - 1 - b) + (lsb ? i : 7 - i);
        slot(wd[k], !rd, q);
        rdat[k] = q;
      end
    oe = last_oe;
    repeat (5) @(posedge i_clk_sys);
    #1 csb_n = 1'b1;
    repeat (5) @(posedge i_clk_sys);
  endtask
endmodule // serial_host_model

/* File: tb_top.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
  import clock_dist_pkg::*;
  localparam logic [55:0] ACT_RST = 56'h00_0000_0002_0000;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  serial_pins_t pins;
  logic sdio, sdio_oe_n, serial_data_out_pin, sdo_oe_n, soft_reset;
  active_regs_t act;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic lsb_mode = 1'b0;
  logic [31:0] rd;
  logic [1:0] oe;

  always #2.5 i_clk_sys = ~i_clk_sys;

  clock_dist_config_regs u_dut (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_pins(pins),
    .o_sdio(sdio), .o_sdio_oe_n(sdio_oe_n), .o_sdo(serial_data_out_pin),
    .o_sdo_oe_n(sdo_oe_n), .o_soft_reset(soft_reset), .o_active(act));

  serial_host_model u_host (
    .i_clk_sys(i_clk_sys), .i_sdio(sdio), .i_sdio_oe_n(sdio_oe_n),
    .i_sdo(serial_data_out_pin), .i_sdo_oe_n(sdo_oe_n), .o_pins(pins));

  task automatic check(input string what, input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input int n, input logic [31:0] d);
    u_host.xfer(lsb_mode, 1'b0, a, n, d, rd, oe);
  endtask

  task automatic rd_chk(input string what, input logic [12:0] a,
                        input logic [7:0] exp);
    u_host.xfer(lsb_mode, 1'b1, a, 1, 32'h0000_0000, rd, oe);
    check(what, rd[7:0], exp);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole run needs about 9500 clk
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    #1 i_arst_n = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    check("active reset", act, ACT_RST);
    check("pins reset", {sdio_oe_n, sdo_oe_n, soft_reset}, 3'b110);
    rd_chk("port cfg reset", ADDR_PORT_CFG, 8'h18);
    $display("test reset done");
    wr(ADDR_VCO_DIV, 1, 32'h0000_0005);
    check("active before update", act, ACT_RST);
    rd_chk("buffer read", ADDR_VCO_DIV, 8'h05);
    wr(ADDR_READBACK, 1, 32'h0000_0001);
    rd_chk("active read", ADDR_VCO_DIV, 8'h02);
    wr(ADDR_UPDATE, 1, 32'h0000_0001);
    check("active after update", act.vco_divide, 8'h05);
    wr(ADDR_READBACK, 1, 32'h0000_0000);
    rd_chk("update cleared", ADDR_UPDATE, 8'h00);
    $display("test update done");
    wr(ADDR_DIV2_AUX, 3, 32'h00a1_b2c3);
    rd_chk("stream 198", ADDR_DIV2_AUX, 8'ha1);
    rd_chk("stream 197", ADDR_DIV2_PHASE, 8'hb2);
    rd_chk("stream 196", ADDR_DIV2_CYCLES, 8'hc3);
    check("bidir oe", oe, 2'b01);
    $display("test msb stream done");
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'ha)));
    lsb_mode = 1'b1;
    wr(ADDR_DIV1_AUX, 2, 32'h0000_1122);
    rd_chk("lsb 195", ADDR_DIV1_AUX, 8'h11);
    rd_chk("lsb 196", ADDR_DIV2_CYCLES, 8'h22);
    rd_chk("lsb cfg", ADDR_PORT_CFG, 8'h5a);
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'h8)));
    lsb_mode = 1'b0;
    rd_chk("msb again", ADDR_DIV2_CYCLES, 8'h22);
    $display("test lsb done");
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'h9)));
    rd_chk("sdo read", ADDR_DIV1_AUX, 8'h11);
    check("sdo oe", oe, 2'b10);
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'h8)));
    wr(ADDR_SYS_RSVD, 1, 32'h0000_00ff);
    rd_chk("reserved", ADDR_SYS_RSVD, 8'h00);
    $display("test sdo and reserved done");
    // count 3 keeps the frame open until chip select rises
    wr(ADDR_DIV2_AUX, 4, 32'h1122_3344);
    u_host.xfer(1'b0, 1'b1, ADDR_DIV2_AUX, 4, 32'h0000_0000, rd, oe);
    check("stream read", rd, 32'h1122_3344);
    $display("test stream done");
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'hc)));
    check("soft reset on", soft_reset, 1'b1);
    check("soft reset active", act, ACT_RST);
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'h8)));
    check("soft reset off", soft_reset, 1'b0);
    rd_chk("buffer default", ADDR_DIV2_CYCLES, 8'h00);
    rd_chk("cfg kept", ADDR_PORT_CFG, 8'h18);
    $display("test soft reset done");
    wr(ADDR_VCO_DIV, 1, 32'h0000_0007);
    wr(ADDR_UPDATE, 1, 32'h0000_0001);
    check("active pre reset", act.vco_divide, 8'h07);
    // leave lsb-first and output-pin mode set so reset must clear them
    wr(ADDR_PORT_CFG, 1, 32'(u_host.cfg_byte(4'hb)));
    @(posedge i_clk_sys);
    #1 i_arst_n = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1 i_arst_n = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    check("rerun active", act, ACT_RST);
    rd_chk("rerun cfg", ADDR_PORT_CFG, 8'h18);
    check("rerun oe", oe, 2'b01);
    rd_chk("rerun buffer", ADDR_VCO_DIV, 8'h02);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_top
